// ==== core/dw_pkg.sv ====
// Operation
// - wiper value 00h low end, FFh high end
// - power-up loads both wipers with 80h
// - addresses 0, 1, 10h select the registers
// - control bit 6 low shuts both channels down
// - after reset control reads 40h
// - shutdown keeps wiper values, restores on exit
// - brown-out during shutdown recentres both wipers
// - bytes travel most significant bit first
// - sample on clock rise, drive after fall
// - master moves data only while clock low; the master's start and stop move it while clock high
// - ignore traffic until a start condition
// - ignore start while still powering up
// - data line released until addressed
// - stop returns the device to standby
// - receiver pulls data low on ninth clock
// - acknowledge identification, address and write data
// - identification: type code, straps, read/write bit
// - write data commits on ninth clock
// - further data bytes write further registers (code alternates 0 and 1, and writes 10h again)
// - read: address write, repeated start, read
// - master acks wanted bytes, nacks last, stops
package dw_pkg;
  localparam int CLK_MHZ = 200;
  localparam int NS_PER_US = 1000;
  // device type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
  localparam logic [7:0] REG_WIPER_0 = 8'h00;
  localparam logic [7:0] REG_WIPER_1 = 8'h01;
  localparam logic [7:0] REG_ACCESS_CONTROL = 8'h10;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] ACR_RESET = 8'h40;
  localparam int PDN_BIT = 6;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] QTR_LAST = 2'h3;
  // brown-out must last at least this long before the wipers recentre
  localparam int BROWNOUT_NS = 200;
  localparam int BROWNOUT_CYC = (BROWNOUT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int POWERUP_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  // one quarter of the master's serial clock period
  localparam int SCL_QTR_NS = 625;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
endpackage

// ==== core/dw_i2c_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dw_i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-ups
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
  modport device (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
                  output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// ==== core/dw_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module dw_slave
#(
  parameter int POWERUP_CYCLES = dw_pkg::POWERUP_CYC,
  parameter int BROWNOUT_CYCLES = dw_pkg::BROWNOUT_CYC
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  dw_i2c_if.device bus,
  input wire logic i_addr_strap_2,
  input wire logic i_addr_strap_1,
  input wire logic i_addr_strap_0,
  input wire logic i_supply_low,
  output logic [7:0] o_wiper_position_0,
  output logic [7:0] o_wiper_position_1,
  output logic o_power_down_n,
  output logic o_addressed
);
  import dw_pkg::*;

  localparam int PU_W = $clog2(POWERUP_CYCLES + 1);
  localparam int BO_W = $clog2(BROWNOUT_CYCLES + 1);

  typedef enum logic [2:0]
  {
    DS_IDLE = 3'h0,
    DS_RX = 3'h1,
    DS_ACK = 3'h2,
    DS_TX = 3'h3,
    DS_TXACK = 3'h4,
    DS_TXLD = 3'h5,
    DS_WAIT = 3'h6
  } dw_dstate_t;

  typedef enum logic [1:0]
  {
    K_ID = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h2
  } dw_kind_t;

  typedef struct packed
  {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [2:0] strap_m;
    logic [2:0] strap_s;
    logic low_m;
    logic low_s;
    dw_dstate_t st;
    dw_kind_t kind;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rd;
    logic [7:0] w0;
    logic [7:0] w1;
    logic pdn;
    logic sda_oe;
    logic sda_out;
    logic [PU_W-1:0] pu_cnt;
    logic pu_done;
    logic [BO_W-1:0] bo_cnt;
    logic addressed;
  } dw_dev_state_t;

  dw_dev_state_t q;
  dw_dev_state_t next_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] acr_val;
  logic [7:0] rd_byte;
  logic [7:0] ptr_adv;
  logic id_match;

  // edges come from the second and third flops only
  assign scl_rise = q.scl_s & ~q.scl_p;
  assign scl_fall = ~q.scl_s & q.scl_p;
  assign start_cond = q.scl_s & q.scl_p & ~q.sda_s & q.sda_p;
  assign stop_cond = q.scl_s & q.scl_p & q.sda_s & ~q.sda_p;
  assign acr_val = ACR_RESET & {8{q.pdn}};
  assign rd_byte = (q.ptr == REG_WIPER_0) ? q.w0 :
                   (q.ptr == REG_WIPER_1) ? q.w1 :
                   (q.ptr == REG_ACCESS_CONTROL) ? acr_val : 8'h00;
  assign ptr_adv = (q.ptr == REG_WIPER_0) ? REG_WIPER_1 :
                   (q.ptr == REG_WIPER_1) ? REG_WIPER_0 : q.ptr;
  assign id_match = (q.sh[7:4] == DEV_TYPE_CODE) && (q.sh[3:1] == q.strap_s);

  always_comb
  begin
    next_q = q;
    next_q.scl_m = bus.scl;
    next_q.scl_s = q.scl_m;
    next_q.scl_p = q.scl_s;
    next_q.sda_m = bus.sda;
    next_q.sda_s = q.sda_m;
    next_q.sda_p = q.sda_s;
    next_q.strap_m = {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
    next_q.strap_s = q.strap_m;
    next_q.low_m = i_supply_low;
    next_q.low_s = q.low_m;
    if (!q.pu_done)
    begin
      next_q.pu_cnt = q.pu_cnt + PU_W'(1);
      if (q.pu_cnt == PU_W'(POWERUP_CYCLES - 1))
      begin
        next_q.pu_done = 1'b1;
      end
    end
    // supply dip while shut down recentres both wipers
    if (!q.pdn && q.low_s)
    begin
      if (q.bo_cnt == BO_W'(BROWNOUT_CYCLES - 1))
      begin
        next_q.w0 = WIPER_RESET;
        next_q.w1 = WIPER_RESET;
      end
      else
      begin
        next_q.bo_cnt = q.bo_cnt + BO_W'(1);
      end
    end
    else
    begin
      next_q.bo_cnt = '0;
    end
    unique case (q.st)
      DS_IDLE, DS_WAIT:
      begin
        next_q.sda_oe = 1'b0;
      end
      DS_RX:
      begin
        if (scl_rise)
        begin
          next_q.sh = {q.sh[6:0], q.sda_s};
          next_q.bitcnt = q.bitcnt + 4'h1;
        end
        else if (scl_fall && q.bitcnt == BYTE_BITS)
        begin
          next_q.bitcnt = 4'h0;
          unique case (q.kind)
            K_ID:
            begin
              if (id_match)
              begin
                next_q.rd = (q.sh[0] == RW_READ);
                next_q.sda_oe = 1'b1;
                next_q.st = DS_ACK;
              end
              else
              begin
                next_q.st = DS_WAIT;
              end
            end
            K_ADDR:
            begin
              next_q.ptr = q.sh;
              next_q.sda_oe = 1'b1;
              next_q.st = DS_ACK;
            end
            K_DATA:
            begin
              next_q.sda_oe = 1'b1;
              next_q.st = DS_ACK;
            end
            default:
            begin
              next_q.st = DS_WAIT;
            end
          endcase
        end
      end
      DS_ACK:
      begin
        if (scl_rise && q.kind == K_DATA)
        begin
          // ninth clock of a data byte
          if (q.ptr == REG_WIPER_0)
          begin
            next_q.w0 = q.sh;
          end
          else if (q.ptr == REG_WIPER_1)
          begin
            next_q.w1 = q.sh;
          end
          else if (q.ptr == REG_ACCESS_CONTROL)
          begin
            next_q.pdn = q.sh[PDN_BIT];
          end
          next_q.ptr = ptr_adv;
        end
        if (scl_fall)
        begin
          next_q.sda_oe = 1'b0;
          next_q.bitcnt = 4'h0;
          if (q.kind == K_ID && q.rd)
          begin
            next_q.sh = rd_byte;
            next_q.sda_oe = ~rd_byte[7];
            next_q.st = DS_TX;
          end
          else
          begin
            next_q.kind = (q.kind == K_ID) ? K_ADDR : K_DATA;
            next_q.st = DS_RX;
          end
        end
      end
      DS_TX:
      begin
        if (scl_fall)
        begin
          if (q.bitcnt == BIT_LAST)
          begin
            next_q.sda_oe = 1'b0;
            next_q.st = DS_TXACK;
          end
          else
          begin
            next_q.bitcnt = q.bitcnt + 4'h1;
            next_q.sh = {q.sh[6:0], 1'b0};
            next_q.sda_oe = ~q.sh[6];
          end
        end
      end
      DS_TXACK:
      begin
        if (scl_rise)
        begin
          if (!q.sda_s)
          begin
            next_q.ptr = ptr_adv;
            next_q.st = DS_TXLD;
          end
          else
          begin
            next_q.st = DS_WAIT;
          end
        end
      end
      DS_TXLD:
      begin
        if (scl_fall)
        begin
          next_q.sh = rd_byte;
          next_q.sda_oe = ~rd_byte[7];
          next_q.bitcnt = 4'h0;
          next_q.st = DS_TX;
        end
      end
      default:
      begin
        next_q.st = DS_IDLE;
      end
    endcase
    if (stop_cond)
    begin
      next_q.st = DS_IDLE;
      next_q.sda_oe = 1'b0;
    end
    if (start_cond && q.pu_done)
    begin
      next_q.st = DS_RX;
      next_q.kind = K_ID;
      next_q.bitcnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end
    // registered so the output comes straight from a flop
    next_q.addressed = (next_q.st != DS_IDLE) && (next_q.st != DS_WAIT) &&
                       (next_q.kind != K_ID);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= DS_IDLE;
      q.kind <= K_ID;
      q.w0 <= WIPER_RESET;
      q.w1 <= WIPER_RESET;
      q.pdn <= ACR_RESET[PDN_BIT];
    end
    else
    begin
      q <= next_q;
    end
  end

  // register value is the tap index counted from the low terminal
  assign o_wiper_position_0 = q.w0;
  assign o_wiper_position_1 = q.w1;
  assign o_power_down_n = q.pdn;
  assign o_addressed = q.addressed;
  assign bus.s_sda_o = q.sda_out;
  assign bus.s_sda_oe = q.sda_oe;
endmodule
`default_nettype wire

// ==== core/dw_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module dw_master
#(
  parameter int MAX_BYTES = 2,
  parameter int QTR_CYCLES = dw_pkg::SCL_QTR_CYC
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  dw_i2c_if.master bus,
  input wire logic i_go,
  input wire logic i_read,
  input wire logic [2:0] i_strap,
  input wire logic [7:0] i_reg_addr,
  input wire logic [$clog2(MAX_BYTES+1)-1:0] i_count,
  input wire logic [8*MAX_BYTES-1:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [8*MAX_BYTES-1:0] o_rdata
);
  import dw_pkg::*;

  localparam int CNT_W = $clog2(MAX_BYTES + 1);
  localparam int IDX_W = $clog2(MAX_BYTES + 4);
  localparam int DIV_W = $clog2(QTR_CYCLES + 1);
  localparam int DW = 8 * MAX_BYTES;

  typedef enum logic [1:0]
  {
    MS_IDLE = 2'h0,
    MS_START = 2'h1,
    MS_BIT = 2'h2,
    MS_STOP = 2'h3
  } dw_mstate_t;

  typedef struct packed
  {
    logic sda_m;
    logic sda_s;
    dw_mstate_t st;
    logic [1:0] qtr;
    logic [DIV_W-1:0] div;
    logic [3:0] bitn;
    logic [IDX_W-1:0] idx;
    logic [7:0] sh;
    logic [CNT_W-1:0] cnt;
    logic rd;
    logic [2:0] strap;
    logic [7:0] regad;
    logic [DW-1:0] wbuf;
    logic [DW-1:0] rbuf;
    logic scl_oe;
    logic sda_oe;
    logic drive_lvl;
    logic busy;
    logic done;
    logic nack;
  } dw_mst_state_t;

  dw_mst_state_t q;
  dw_mst_state_t next_q;
  logic rxing;
  logic last_rx;
  logic [7:0] tx_byte;
  logic [7:0] cur;
  logic [IDX_W-1:0] cnt_x;

  assign cnt_x = IDX_W'(q.cnt);
  assign rxing = q.rd && (q.idx > IDX_W'(2));
  assign last_rx = (q.idx == cnt_x + IDX_W'(2));
  assign tx_byte = (q.idx == '0) ? {DEV_TYPE_CODE, q.strap, 1'b0} :
                   (q.idx == IDX_W'(1)) ? q.regad :
                   q.rd ? {DEV_TYPE_CODE, q.strap, RW_READ} : q.wbuf[7:0];
  assign cur = (q.bitn == 4'h0) ? tx_byte : q.sh;

  always_comb
  begin
    next_q = q;
    next_q.done = 1'b0;
    next_q.sda_m = bus.sda;
    next_q.sda_s = q.sda_m;
    if (q.st == MS_IDLE)
    begin
      if (i_go)
      begin
        next_q.rd = i_read;
        next_q.strap = i_strap;
        next_q.regad = i_reg_addr;
        next_q.cnt = i_count;
        next_q.wbuf = i_wdata;
        next_q.busy = 1'b1;
        next_q.nack = 1'b0;
        next_q.idx = '0;
        next_q.qtr = 2'h0;
        next_q.div = '0;
        next_q.st = MS_START;
      end
    end
    else if (q.div != DIV_W'(QTR_CYCLES - 1))
    begin
      next_q.div = q.div + DIV_W'(1);
    end
    else
    begin
      next_q.div = '0;
      next_q.qtr = q.qtr + 2'h1;
      unique case (q.st)
        MS_START:
        begin
          // release data, raise clock, pull data low, then clock low
          unique case (q.qtr)
            2'h0: next_q.sda_oe = 1'b0;
            2'h1: next_q.scl_oe = 1'b0;
            2'h2: next_q.sda_oe = 1'b1;
            default:
            begin
              next_q.scl_oe = 1'b1;
              next_q.bitn = 4'h0;
              next_q.st = MS_BIT;
            end
          endcase
        end
        MS_BIT:
        begin
          unique case (q.qtr)
            2'h0:
            begin
              // data changes only while the clock is low
              next_q.sh = cur;
              if (q.bitn == BYTE_BITS)
              begin
                next_q.sda_oe = rxing && !last_rx;
              end
              else
              begin
                next_q.sda_oe = !rxing && !cur[7];
              end
            end
            2'h1: next_q.scl_oe = 1'b0;
            2'h2:
            begin
              if (q.bitn != BYTE_BITS)
              begin
                next_q.sh = {q.sh[6:0], q.sda_s};
              end
              else if (!rxing && q.sda_s)
              begin
                next_q.nack = 1'b1;
              end
            end
            default:
            begin
              next_q.scl_oe = 1'b1;
              next_q.bitn = q.bitn + 4'h1;
              if (q.bitn == BYTE_BITS)
              begin
                next_q.bitn = 4'h0;
                if (rxing)
                begin
                  next_q.rbuf = {q.rbuf[DW-9:0], q.sh};
                end
                if (q.nack || (!q.rd && q.idx == cnt_x + IDX_W'(1)) || (rxing && last_rx))
                begin
                  next_q.st = MS_STOP;
                end
                else if (q.rd && q.idx == IDX_W'(1))
                begin
                  next_q.idx = IDX_W'(2);
                  next_q.st = MS_START;
                end
                else
                begin
                  next_q.idx = q.idx + IDX_W'(1);
                  if (!q.rd && q.idx > IDX_W'(1))
                  begin
                    next_q.wbuf = q.wbuf >> 8;
                  end
                end
              end
            end
          endcase
        end
        MS_STOP:
        begin
          unique case (q.qtr)
            2'h0: next_q.sda_oe = 1'b1;
            2'h1: next_q.scl_oe = 1'b0;
            2'h2: next_q.sda_oe = 1'b0;
            default:
            begin
              next_q.busy = 1'b0;
              next_q.done = 1'b1;
              next_q.st = MS_IDLE;
            end
          endcase
        end
        default:
        begin
          next_q.st = MS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      q <= '0;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.st <= MS_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign bus.m_scl_o = q.drive_lvl;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_o = q.drive_lvl;
  assign bus.m_sda_oe = q.sda_oe;
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_nack = q.nack;
  assign o_rdata = q.rbuf;
endmodule
`default_nettype wire

// ==== testbench/dw_i2c_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dw_i2c_asserts
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe
);
  import dw_pkg::*;
  logic scl_q, sda_q, rd, acked, idle;
  logic [3:0] cnt, since_fall;
  logic [2:0] bidx;
  logic start, stop, rise, nine;
  // wire-level view of the frame: bit count, byte index, id direction and answer
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  assign rise = scl && !scl_q;
  assign nine = rise && (cnt == 4'h8);
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {scl_q, sda_q, rd, acked, idle} <= 5'h1b;
      cnt <= 4'h0;
      since_fall <= 4'hf;
      bidx <= 3'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      since_fall <= (scl_q && !scl) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
      if (stop)
        idle <= 1'b1;
      if (start)
      begin
        {cnt, bidx, rd, idle} <= 9'h0;
      end
      else if (rise)
        cnt <= nine ? 4'h0 : cnt + 4'h1;
      // direction bit is the eighth bit of the id byte
      if (rise && cnt == 4'h7 && bidx == 3'h0)
        rd <= sda;
      if (nine)
      begin
        bidx <= bidx + {2'h0, bidx != 3'h7};
        if (bidx == 3'h0)
          acked <= !sda;
      end
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_data_ninth;
    nine && (bidx != 3'h0);
  endsequence
  a_reset_released: assert property ($rose(i_resetn) |-> !s_sda_oe)
    else $error("slave drives sda right after reset");
  a_quiet_idle: assert property (idle |-> !s_sda_oe)
    else $error("slave drives sda between stop and start");
  a_drive_after_fall: assert property ($changed(s_sda_oe) |-> !scl && since_fall <= 4'h8)
    else $error("slave sda change not shortly after scl fall");
  a_ack_ninth_only: assert property ($rose(s_sda_oe) && !rd |-> cnt == 4'h8 && !scl)
    else $error("slave pulls sda outside the ninth clock");
  a_id_nack_quiet: assert property (bidx != 3'h0 && !acked |-> !s_sda_oe)
    else $error("slave answers after an unmatched id");
  a_write_byte_ack: assert property (s_data_ninth ##0 (acked && !rd) |-> !sda)
    else $error("write byte not acknowledged");
  a_read_release: assert property (s_data_ninth ##0 rd |-> !s_sda_oe)
    else $error("slave holds sda in the master answer slot");
  a_master_steady: assert property ($changed(m_sda_oe) |-> !scl || cnt <= 4'h1)
    else $error("master moves sda while scl high");
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dw_pkg::*;
  localparam int PWR = 40;
  localparam int BRN = 4;
  logic i_clk, i_resetn, i_go, i_read, i_supply_low;
  logic [2:0] i_strap, strap;
  logic [7:0] i_reg_addr, o_wiper_position_0, o_wiper_position_1;
  logic [1:0] i_count;
  logic [15:0] i_wdata, o_rdata;
  logic o_busy, o_done, o_nack, o_addressed, o_power_down_n;
  logic addr_seen;
  int n_mismatch, n_compared;
  dw_i2c_if bus ();
  dw_slave #(.POWERUP_CYCLES(PWR), .BROWNOUT_CYCLES(BRN)) i_dw_slave (.i_clk(i_clk),
    .i_resetn(i_resetn), .bus(bus), .i_addr_strap_2(strap[2]), .i_addr_strap_1(strap[1]),
    .i_addr_strap_0(strap[0]), .i_supply_low(i_supply_low),
    .o_wiper_position_0(o_wiper_position_0), .o_wiper_position_1(o_wiper_position_1),
    .o_power_down_n(o_power_down_n), .o_addressed(o_addressed));
  dw_master #(.MAX_BYTES(2), .QTR_CYCLES(8)) i_dw_master (.i_clk(i_clk), .i_resetn(i_resetn),
    .bus(bus), .i_go(i_go), .i_read(i_read), .i_strap(i_strap), .i_reg_addr(i_reg_addr),
    .i_count(i_count), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack),
    .o_rdata(o_rdata));
  dw_i2c_asserts i_dw_i2c_asserts (.i_clk(i_clk), .i_resetn(i_resetn), .scl(bus.scl),
    .sda(bus.sda), .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe));
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one master transaction, waits for the done pulse under a bound
  task automatic xfer(input logic rd, input logic [2:0] st, input logic [7:0] ad,
                      input logic [1:0] n, input logic [15:0] wd);
    int k;
    @(posedge i_clk);
    i_go <= 1'b1;
    i_read <= rd;
    i_strap <= st;
    i_reg_addr <= ad;
    i_count <= n;
    i_wdata <= wd;
    @(posedge i_clk);
    i_go <= 1'b0;
    k = 0;
    addr_seen = 1'b0;
    do
    begin
      @(negedge i_clk);
      k++;
      addr_seen = addr_seen | o_addressed;
    end
    while (o_done !== 1'b1 && k < 5000);
    if (k >= 5000)
    begin
      n_mismatch++;
      $display("unexpected transfer end: expected done, seen timeout");
      close_out();
    end
  endtask
  task automatic brown_out();
    @(posedge i_clk);
    i_supply_low <= 1'b1;
    repeat (BRN + 20) @(posedge i_clk);
    i_supply_low <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  initial
  begin
    {i_resetn, i_go, i_read, i_supply_low} = 4'h0;
    {i_reg_addr, i_count, i_wdata} = 26'h0;
    i_strap = 3'h5;
    strap = 3'h5;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    // first start lands inside the power-up window
    xfer(1'b0, 3'h5, REG_WIPER_0, 2'h1, 16'h0011);
    chk("early id nack", o_nack, 16'h1);
    chk("early not addressed", addr_seen, 16'h0);
    chk("standby after stop", o_addressed, 16'h0);
    chk("wiper 0 reset", o_wiper_position_0, WIPER_RESET);
    chk("wiper 1 reset", o_wiper_position_1, WIPER_RESET);
    chk("run after reset", o_power_down_n, 16'h1);
    $display("test power-up done");
    xfer(1'b1, 3'h5, REG_WIPER_0, 2'h2, 16'h0);
    chk("read both wipers", o_rdata, {WIPER_RESET, WIPER_RESET});
    xfer(1'b1, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h0);
    chk("control reset", o_rdata[7:0], ACR_RESET);
    chk("read acked", o_nack, 16'h0);
    chk("busy after done", o_busy, 16'h0);
    xfer(1'b0, 3'h5, REG_WIPER_0, 2'h2, 16'hff00);
    chk("write addressed", addr_seen, 16'h1);
    chk("idle after write", o_addressed, 16'h0);
    chk("wiper 0 low end", o_wiper_position_0, 16'h00);
    chk("wiper 1 high end", o_wiper_position_1, 16'hff);
    xfer(1'b1, 3'h5, REG_WIPER_1, 2'h2, 16'h0);
    chk("wrapped read", o_rdata, 16'hff00);
    $display("test register access done");
    for (int s = 0; s < 8; s++)
    begin
      xfer(1'b0, 3'(s), REG_WIPER_0, 2'h1, {8'h00, 5'h02, 3'(s)});
      chk("strap match", o_nack, {15'h0, s != 5});
      chk("strap addressed", addr_seen, {15'h0, s == 5});
    end
    chk("bit order", o_wiper_position_0, 16'h15);
    $display("test identification done");
    brown_out();
    chk("no recentre running", o_wiper_position_0, 16'h15);
    xfer(1'b0, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h00bf);
    chk("shutdown entered", o_power_down_n, 16'h0);
    chk("wiper kept", o_wiper_position_0, 16'h15);
    xfer(1'b1, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h0);
    chk("control in shutdown", o_rdata[7:0], 16'h00);
    xfer(1'b0, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h00ff);
    chk("shutdown left", o_power_down_n, 16'h1);
    chk("wiper restored", o_wiper_position_1, 16'hff);
    xfer(1'b1, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h0);
    chk("control fixed bits", o_rdata[7:0], ACR_RESET);
    xfer(1'b0, 3'h5, REG_ACCESS_CONTROL, 2'h1, 16'h0000);
    brown_out();
    chk("recentre 0", o_wiper_position_0, WIPER_RESET);
    chk("recentre 1", o_wiper_position_1, WIPER_RESET);
    $display("test shutdown done");
    strap <= 3'h2;
    xfer(1'b0, 3'h2, 8'h05, 2'h1, 16'h0077);
    chk("unmapped write acked", o_nack, 16'h0);
    xfer(1'b1, 3'h2, 8'h05, 2'h1, 16'h0);
    chk("unmapped read", o_rdata[7:0], 16'h00);
    chk("wiper untouched", o_wiper_position_0, WIPER_RESET);
    xfer(1'b0, 3'h2, REG_WIPER_1, 2'h1, 16'h003c);
    chk("wiper 1 written", o_wiper_position_1, 16'h3c);
    $display("test unmapped done");
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk("wiper 1 after reset", o_wiper_position_1, WIPER_RESET);
    chk("run after reset", o_power_down_n, 16'h1);
    repeat (PWR + 4) @(posedge i_clk);
    xfer(1'b1, 3'h2, REG_WIPER_1, 2'h1, 16'h0);
    chk("read after reset", o_rdata[7:0], WIPER_RESET);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
